// *** rtl/positioner_command_port.sv ***
// parallel command port: pin handshake, motion sequencing and register slave
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module positioner_command_port #(
  parameter int DEBOUNCE_CYCLES = positioner_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic moveStartIn, // start pin
  input wire logic [12:0] posBcdIn, // position number pins
  input wire logic motionHoldIn, // hold pin
  input wire logic motionCancelIn, // cancel pin
  input wire logic controllerRestartIn, // restart pin
  input wire logic interpSelIn, // interpolation select pin
  input wire logic initDoneIn, // controller initialisation done
  input wire logic coldErrIn, // error of cold level or higher
  input wire logic alarmIn, // alarm from controller
  input wire logic servoOnIn, // servo is on
  input wire logic inPositionIn, // deviation inside in-position band
  input wire logic homeDoneIn, // home return finished, pulse
  input wire logic homeReversedIn, // reversed at mechanical end
  input wire logic sysBattLowIn, // system-memory battery low level
  input wire logic absBattLowIn, // absolute-data battery low level
  output logic readyOut, // ready pin
  output logic faultOut, // alarm pin
  output logic moveCompleteOut, // positioning complete pin
  output logic sysmemBattLowOut, // system-memory battery low pin
  output logic absdataBattLowOut, // absolute-data battery low pin
  output logic moveGo, // one-cycle move launch
  output logic homeGo, // one-cycle home return launch
  output logic holdCmd, // decelerate and keep remaining distance
  output logic cancelGo, // one-cycle discard of remaining distance
  output logic interpCmd, // launch both axes together
  output logic [10:0] targetPos, // position number for the launch
  output logic restartOut // one-cycle controller restart
);

  // -------------------------------------------------------------------------
  // reset release and pin filtering
  // -------------------------------------------------------------------------
  logic rstMeta;
  logic rstN;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  logic [17:0] pinsDb;
  input_debouncer #(
    .W(18),
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk(clk),
    .rstN(rstN),
    .ce(ce),
    .pinIn({interpSelIn, controllerRestartIn, motionCancelIn, motionHoldIn,
      moveStartIn, posBcdIn}),
    .levelOut(pinsDb)
  );

  logic [12:0] posDb;
  logic startDb;
  logic holdDb;
  logic cancelDb;
  logic restartDb;
  logic interpDb;
  assign posDb = pinsDb[12:0];
  assign startDb = pinsDb[13];
  assign holdDb = pinsDb[14];
  assign cancelDb = pinsDb[15];
  assign restartDb = pinsDb[16];
  assign interpDb = pinsDb[17];

  logic [10:0] posNum;
  logic posZero;
  logic posOk;
  bcd_position_decoder u_bcd (
    .bcdIn(posDb),
    .posNum(posNum),
    .isZero(posZero),
    .inRange(posOk)
  );

  // -------------------------------------------------------------------------
  // registers written by software
  // -------------------------------------------------------------------------
  logic [7:0] mode_reg;
  logic twoAxis_reg;
  logic legacy;
  assign legacy = (mode_reg == positioner_pkg::MODE_LEGACY);

  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic addrPhase;
  assign addrPhase = hsel && htrans[1] && hready;
  logic errClr;
  assign errClr = wrPend_reg && (wrAddr_reg == positioner_pkg::CTRL_OFFS)
    && hwdata[positioner_pkg::CTRL_ERRCLR_BIT];

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end
    else if (ce)
    begin
      wrPend_reg <= addrPhase && hwrite;
      wrAddr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mode_reg <= positioner_pkg::MODE_RESET;
      twoAxis_reg <= positioner_pkg::CTRL_TWOAXIS_RESET;
    end
    else if (ce && wrPend_reg)
    begin
      if (wrAddr_reg == positioner_pkg::MODE_OFFS)
        mode_reg <= hwdata[7:0];
      if (wrAddr_reg == positioner_pkg::CTRL_OFFS)
        twoAxis_reg <= hwdata[positioner_pkg::CTRL_TWOAXIS_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // edge detection and restart
  // -------------------------------------------------------------------------
  logic startPrev_reg;
  logic restartPrev_reg;
  logic startRise;
  logic restartRise;
  assign startRise = startDb && !startPrev_reg;
  assign restartRise = restartDb && !restartPrev_reg;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      startPrev_reg <= 1'b0;
      restartPrev_reg <= 1'b0;
      restartOut <= 1'b0;
    end
    else if (ce)
    begin
      startPrev_reg <= startDb;
      restartPrev_reg <= restartDb;
      restartOut <= restartRise;
    end
  end

  // -------------------------------------------------------------------------
  // motion sequencer
  // -------------------------------------------------------------------------
  positioner_pkg::motion_state_e state_reg;
  logic homed_reg;
  logic complete_reg;
  logic rehome_reg;
  logic err_reg;
  logic [11:0] errCode_reg;

  // hold and cancel are active high only in the legacy mode
  logic holdAct;
  logic cancelAct;
  assign holdAct = legacy ? holdDb : !holdDb;
  assign cancelAct = legacy ? cancelDb : !cancelDb;

  logic accept;
  assign accept = legacy && startRise && readyOut
    && (state_reg == positioner_pkg::ST_IDLE);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_reg <= positioner_pkg::ST_IDLE;
      homed_reg <= 1'b0;
      complete_reg <= 1'b0;
      rehome_reg <= 1'b0;
      moveGo <= 1'b0;
      homeGo <= 1'b0;
      cancelGo <= 1'b0;
      holdCmd <= 1'b0;
      interpCmd <= 1'b0;
      targetPos <= 11'h000;
    end
    else if (ce)
    begin
      moveGo <= 1'b0;
      homeGo <= 1'b0;
      cancelGo <= 1'b0;
      if (restartRise)
      begin
        // a restart forgets homing, so the next move needs a home return
        state_reg <= positioner_pkg::ST_IDLE;
        homed_reg <= 1'b0;
        complete_reg <= 1'b0;
        rehome_reg <= 1'b0;
        holdCmd <= 1'b0;
        cancelGo <= 1'b1;
      end
      else
      begin
        case (state_reg)
          positioner_pkg::ST_IDLE:
          begin
            if (accept && posZero)
            begin
              homeGo <= 1'b1;
              complete_reg <= 1'b0;
              targetPos <= 11'h000;
              state_reg <= positioner_pkg::ST_HOMING;
            end
            else if (accept && homed_reg && posOk)
            begin
              moveGo <= 1'b1;
              targetPos <= posNum;
              interpCmd <= twoAxis_reg && interpDb;
              complete_reg <= 1'b0;
              state_reg <= positioner_pkg::ST_MOVING;
            end
          end
          positioner_pkg::ST_MOVING:
          begin
            if (cancelAct)
            begin
              cancelGo <= 1'b1;
              state_reg <= positioner_pkg::ST_IDLE;
            end
            else if (holdAct)
            begin
              holdCmd <= 1'b1;
              state_reg <= positioner_pkg::ST_HELD;
            end
            else if (inPositionIn)
            begin
              complete_reg <= 1'b1;
              state_reg <= positioner_pkg::ST_IDLE;
            end
          end
          positioner_pkg::ST_HELD:
          begin
            if (cancelAct)
            begin
              holdCmd <= 1'b0;
              cancelGo <= 1'b1;
              state_reg <= positioner_pkg::ST_IDLE;
            end
            else if (!holdAct)
            begin
              holdCmd <= 1'b0;
              state_reg <= positioner_pkg::ST_MOVING;
            end
          end
          positioner_pkg::ST_HOMING:
          begin
            if (cancelAct)
            begin
              cancelGo <= 1'b1;
              state_reg <= positioner_pkg::ST_IDLE;
            end
            else if (homeDoneIn)
            begin
              homed_reg <= 1'b1;
              complete_reg <= 1'b1;
              state_reg <= positioner_pkg::ST_IDLE;
            end
            else if (holdAct)
            begin
              holdCmd <= 1'b1;
              rehome_reg <= homeReversedIn;
              state_reg <= positioner_pkg::ST_HOME_HELD;
            end
          end
          positioner_pkg::ST_HOME_HELD:
          begin
            if (cancelAct)
            begin
              holdCmd <= 1'b0;
              cancelGo <= 1'b1;
              state_reg <= positioner_pkg::ST_IDLE;
            end
            else if (!holdAct)
            begin
              // after reversal the search restarts from the beginning
              holdCmd <= 1'b0;
              homeGo <= rehome_reg;
              rehome_reg <= 1'b0;
              state_reg <= positioner_pkg::ST_HOMING;
            end
          end
          default:
            state_reg <= positioner_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // command errors
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      err_reg <= 1'b0;
      errCode_reg <= 12'h000;
    end
    else if (ce)
    begin
      // a new rejection wins over a clear in the same cycle
      if (accept && !posZero && !homed_reg)
      begin
        err_reg <= 1'b1;
        errCode_reg <= positioner_pkg::ERR_NOT_HOMED;
      end
      else if (accept && !posZero && !posOk)
      begin
        err_reg <= 1'b1;
        errCode_reg <= positioner_pkg::ERR_BAD_POSITION;
      end
      else if (errClr || restartRise)
        err_reg <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // output pins
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      readyOut <= 1'b0;
      faultOut <= 1'b0;
      moveCompleteOut <= 1'b0;
      sysmemBattLowOut <= 1'b0;
      absdataBattLowOut <= 1'b0;
    end
    else if (ce)
    begin
      readyOut <= initDoneIn && !coldErrIn;
      // other modes drive the alarm pin as normally on
      faultOut <= legacy ? (alarmIn || err_reg) : !(alarmIn || err_reg);
      moveCompleteOut <= complete_reg && !holdAct && servoOnIn;
      sysmemBattLowOut <= sysBattLowIn;
      absdataBattLowOut <= absBattLowIn;
    end
  end

  // -------------------------------------------------------------------------
  // bus read path, zero wait states
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      if (addrPhase && !hwrite)
      begin
        case (haddr[7:0])
          positioner_pkg::MODE_OFFS:
            hrdata <= {24'h00_0000, mode_reg};
          positioner_pkg::CTRL_OFFS:
            hrdata <= {31'h0000_0000, twoAxis_reg};
          positioner_pkg::STATUS_OFFS:
            hrdata <= {21'h00_0000, state_reg, 2'b00, legacy, err_reg,
              homed_reg, moveCompleteOut, faultOut, readyOut};
          positioner_pkg::ERRCODE_OFFS:
            hrdata <= {20'h0_0000, errCode_reg};
          positioner_pkg::TARGET_OFFS:
            hrdata <= {21'h00_0000, targetPos};
          default:
            hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : positioner_command_port

// *** rtl/positioner_pkg.sv ***
// constants and helpers for the parallel command port of the positioner
// What this block does
// - legacy port behaviour only when mode equals 16
// - debounced start rise launches move to position
// - position number is 13-bit BCD, sampled at start
// - accepted move targets are 1 through 1500
// - start with position zero runs home return
// - move before first homing rejected, code C6F
// - hold stops motion, release resumes remaining distance
// - hold in homing pauses, after reversal restarts homing
// - cancel stops motion and discards remaining distance
// - restart input restarts the controller
// - interpolation select launches both axes together
// - ready after init, drops on cold error
// - fault active high; hold, cancel active high
// - complete low at start, high in band, sticky
// - complete low during hold, servo off, power-up
// - two separate battery-low outputs
// - command pin inputs change only after 6 ms stable
// - complete low within 60 ms of start
package positioner_pkg;

  // -------------------------------------------------------------------------
  // register map (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [7:0] MODE_OFFS = 8'h00;
  localparam logic [7:0] CTRL_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  localparam logic [7:0] ERRCODE_OFFS = 8'h0C;
  localparam logic [7:0] TARGET_OFFS = 8'h10;

  localparam logic [7:0] MODE_RESET = 8'h10;
  localparam logic [7:0] MODE_LEGACY = 8'h10;
  localparam int CTRL_TWOAXIS_BIT = 0;
  localparam int CTRL_ERRCLR_BIT = 1;
  localparam logic CTRL_TWOAXIS_RESET = 1'b0;

  localparam int STAT_READY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_COMPLETE_BIT = 2;
  localparam int STAT_HOMED_BIT = 3;
  localparam int STAT_ERR_BIT = 4;
  localparam int STAT_LEGACY_BIT = 5;
  localparam int STAT_STATE_LSB = 8;

  // -------------------------------------------------------------------------
  // error codes and position limits
  // -------------------------------------------------------------------------
  localparam logic [11:0] ERR_NOT_HOMED = 12'hC6F;
  localparam logic [11:0] ERR_BAD_POSITION = 12'h0A1;
  localparam logic [10:0] POS_MIN = 11'h001;
  localparam logic [10:0] POS_MAX = 11'h5DC;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int DEBOUNCE_US = 6000;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_US;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MOVING,
    ST_HELD,
    ST_HOMING,
    ST_HOME_HELD
  } motion_state_e;

  function automatic logic [3:0] bcdDigit(input logic [3:0] d);
    bcdDigit = (d > 4'h9) ? 4'hF : d;
  endfunction : bcdDigit

endpackage : positioner_pkg

// *** rtl/input_debouncer.sv ***
// three-stage synchroniser and stable-time filter for pin inputs
`timescale 1ns/1ps
module input_debouncer #(
  parameter int W = 1,
  parameter int STABLE_CYCLES = positioner_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rstN, // synchronised reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] pinIn, // raw pin levels
  output logic [W-1:0] levelOut // filtered levels
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  logic [W-1:0] s1Reg;
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      s1Reg <= '0;
      s2Reg <= '0;
      s3Reg <= '0;
    end
    else if (ce)
    begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic [CW-1:0] cntReg;
    always_ff @(posedge clk or negedge rstN)
    begin
      if (!rstN)
      begin
        cntReg <= '0;
        levelOut[i] <= 1'b0;
      end
      else if (ce)
      begin
        // any disagreement or return to the old level restarts the wait
        if ((s2Reg[i] != s3Reg[i]) || (s3Reg[i] == levelOut[i]))
          cntReg <= '0;
        else if (cntReg == LAST)
        begin
          cntReg <= '0;
          levelOut[i] <= s3Reg[i];
        end
        else
          cntReg <= cntReg + 1'b1;
      end
    end
  end

endmodule : input_debouncer

// *** rtl/bcd_position_decoder.sv ***
// converts the 13-bit BCD position inputs to a binary position number
`timescale 1ns/1ps
module bcd_position_decoder (
  input wire logic [12:0] bcdIn, // thousands bit, hundreds, tens, units
  output logic [10:0] posNum, // binary position number
  output logic isZero, // all position inputs off
  output logic inRange // legal BCD and within move range
);
  logic [3:0] units;
  logic [3:0] tens;
  logic [3:0] hundreds;

  always_comb
  begin
    units = positioner_pkg::bcdDigit(bcdIn[3:0]);
    tens = positioner_pkg::bcdDigit(bcdIn[7:4]);
    hundreds = positioner_pkg::bcdDigit(bcdIn[11:8]);
    posNum = 11'(units) + 11'(tens) * 11'd10 + 11'(hundreds) * 11'd100
      + (bcdIn[12] ? 11'd1000 : 11'd0);
    isZero = (bcdIn == 13'h0000);
    inRange = (units != 4'hF) && (tens != 4'hF) && (hundreds != 4'hF)
      && (posNum >= positioner_pkg::POS_MIN)
      && (posNum <= positioner_pkg::POS_MAX);
  end

endmodule : bcd_position_decoder

// *** dv/positioner_command_port_sva.sv ***
// assertion checker for the pin outputs of the positioner command port
`timescale 1ns/1ps
module positioner_command_port_sva #(
  parameter int DEBOUNCE_CYCLES = 8 // filter length
) (
  input wire logic clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic initDoneIn, // init done
  input wire logic coldErrIn, // cold error
  input wire logic alarmIn, // alarm
  input wire logic servoOnIn, // servo on
  input wire logic inPositionIn, // in band
  input wire logic homeDoneIn, // homing done
  input wire logic sysBattLowIn, // battery level
  input wire logic absBattLowIn, // battery level
  input wire logic motionHoldIn, // hold pin
  input wire logic readyOut, // ready
  input wire logic faultOut, // fault
  input wire logic moveCompleteOut, // complete
  input wire logic sysmemBattLowOut, // battery flag
  input wire logic absdataBattLowOut, // battery flag
  input wire logic moveGo, // move launch
  input wire logic homeGo, // home launch
  input wire logic holdCmd, // hold
  input wire logic cancelGo, // cancel
  input wire logic restartOut, // restart
  input wire logic [10:0] targetPos // target
);
  // outputs lag nrst by the internal release flops; ce assumed high
  logic [2:0] liveCnt;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      liveCnt <= 3'h0;
    else if (liveCnt != 3'h7)
      liveCnt <= liveCnt + 3'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (liveCnt != 3'h7);
  ready_up_a: assert property (initDoneIn && !coldErrIn |=> readyOut)
    else $error("ready missing after init");
  ready_cold_a: assert property (coldErrIn |=> !readyOut)
    else $error("ready kept on cold error");
  batt_copy_a: assert property (
    sysmemBattLowOut == $past(sysBattLowIn) && absdataBattLowOut == $past(absBattLowIn))
    else $error("battery flag wrong");
  start_clear_a: assert property (moveGo || homeGo |=> !moveCompleteOut)
    else $error("complete not cleared at launch");
  hold_low_a: assert property (holdCmd |-> !moveCompleteOut)
    else $error("complete high while held");
  servo_low_a: assert property (!servoOnIn |=> !moveCompleteOut)
    else $error("complete high with servo off");
  done_sticky_a: assert property (moveCompleteOut && servoOnIn && !motionHoldIn
    && !moveGo && !homeGo && !restartOut |=> moveCompleteOut)
    else $error("complete dropped");
  done_cause_a: assert property ($rose(moveCompleteOut) && $past(servoOnIn, 2) |->
    $past(inPositionIn) || $past(inPositionIn, 2) || $past(homeDoneIn) ||
    $past(homeDoneIn, 2) || $past(homeDoneIn, 3))
    else $error("complete rose without cause");
  target_range_a: assert property (moveGo |-> targetPos >= positioner_pkg::POS_MIN
    && targetPos <= positioner_pkg::POS_MAX)
    else $error("launch outside position range");
  restart_cancel_a: assert property (restartOut |-> cancelGo)
    else $error("restart without discard");
  fault_alarm_a: assert property (alarmIn |=> faultOut)
    else $error("fault low during alarm");
endmodule : positioner_command_port_sva

bind positioner_command_port positioner_command_port_sva #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk (.*);

// *** dv/plc_model.sv ***
// behavioural controller driving the discrete command pins
`timescale 1ns/1ps
module plc_model #(
  parameter int T = 24 // scaled stand-in for the 30 ms and 50 ms spacings
) (
  input wire logic clk, // clock
  output logic moveStartIn, // start pin
  output logic [12:0] posBcdIn, // position pins
  output logic motionHoldIn, // hold pin
  output logic motionCancelIn, // cancel pin
  output logic controllerRestartIn, // restart pin
  output logic interpSelIn // interpolation pin
);
  initial
  begin
    {moveStartIn, posBcdIn, motionHoldIn, motionCancelIn} = '0;
    {controllerRestartIn, interpSelIn} = '0;
  end
  // a short len makes a glitch the filter must reject
  task automatic cmdStart(input logic [12:0] bcd, input logic interp, input int len);
    @(posedge clk);
    posBcdIn <= bcd;
    interpSelIn <= interp;
    repeat (T) @(posedge clk);
    moveStartIn <= 1'b1;
    repeat (len) @(posedge clk);
    moveStartIn <= 1'b0;
    repeat (T) @(posedge clk);
    interpSelIn <= 1'b0;
    repeat (2 * T) @(posedge clk);
  endtask : cmdStart
  task automatic setCtl(input logic h, input logic c, input logic r);
    @(posedge clk);
    motionHoldIn <= h;
    motionCancelIn <= c;
    controllerRestartIn <= r;
    repeat (T) @(posedge clk);
  endtask : setCtl
endmodule : plc_model

// *** dv/tb_top.sv ***
// self-checking bench for the positioner command port
`timescale 1ns/1ps
module tb_top;
  localparam int T = 24;
  logic clk = 1'b0;
  logic nrst, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic initDoneIn, coldErrIn, alarmIn, servoOnIn, inPositionIn, homeDoneIn, homeReversedIn;
  logic sysBattLowIn, absBattLowIn, readyOut, faultOut, moveCompleteOut;
  logic sysmemBattLowOut, absdataBattLowOut, moveGo, homeGo, holdCmd, cancelGo;
  logic interpCmd, restartOut, moveStartIn, motionHoldIn, motionCancelIn;
  logic controllerRestartIn, interpSelIn;
  logic [12:0] posBcdIn;
  logic [10:0] targetPos;
  int mismatches, testsRun, cycles, goCnt, homeCnt, cancelCnt, restartCnt;
  always #5 clk = ~clk;
  positioner_command_port #(.DEBOUNCE_CYCLES(8)) dut (
    .*, .ce(1'b1), .hsel(1'b1), .hsize(3'h2), .hready(hreadyout)
  );
  plc_model #(.T(T)) plc (.*);
  always @(posedge clk)
  begin
    goCnt += (moveGo === 1'b1);
    homeCnt += (homeGo === 1'b1);
    cancelCnt += (cancelGo === 1'b1);
    restartCnt += (restartOut === 1'b1);
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      tallyAndFinish();
    end
  end
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tallyAndFinish
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string name);
    ahb(1'b0, a, '0);
    check(name, rd, exp);
  endtask : rdChk
  function automatic logic [12:0] bcd(input int n);
    bcd = {n >= 1000, 4'((n / 100) % 10), 4'((n / 10) % 10), 4'(n % 10)};
  endfunction : bcd
  task automatic inPos;
    inPositionIn <= 1'b1;
    tick(3);
    inPositionIn <= 1'b0;
    tick(3);
  endtask : inPos
  task automatic tReset;
    check("ready", readyOut, 1);
    check("complete", moveCompleteOut, 0);
    check("hresp", hresp, 0);
    rdChk(positioner_pkg::MODE_OFFS, 32'h00000010, "mode");
    rdChk(8'h40, 32'h00000000, "unmapped");
    {coldErrIn, alarmIn, sysBattLowIn} <= 3'h7;
    tick(3);
    check("ready cold", readyOut, 0);
    check("fault", faultOut, 1);
    check("sys batt", {sysmemBattLowOut, absdataBattLowOut}, 2);
    {coldErrIn, alarmIn, sysBattLowIn, absBattLowIn} <= 4'h1;
    tick(3);
    check("fault clear", faultOut, 0);
    check("abs batt", {sysmemBattLowOut, absdataBattLowOut}, 1);
    absBattLowIn <= 1'b0;
  endtask : tReset
  task automatic tNoHome;
    plc.cmdStart(bcd(5), 1'b0, T);
    check("unhomed move", goCnt, 0);
    rdChk(positioner_pkg::ERRCODE_OFFS, 32'h00000C6F, "code");
    check("fault err", faultOut, 1);
    plc.cmdStart(bcd(0), 1'b0, 3);
    check("glitch", homeCnt, 0);
    ahb(1'b1, positioner_pkg::CTRL_OFFS, 32'h00000002);
    tick(3);
    check("err clear", faultOut, 0);
  endtask : tNoHome
  task automatic tHome;
    plc.cmdStart(bcd(0), 1'b0, T);
    check("home", {homeCnt[7:0], 13'h0000, targetPos}, 32'h01000000);
    homeReversedIn <= 1'b1;
    plc.setCtl(1'b1, 1'b0, 1'b0);
    plc.setCtl(1'b0, 1'b0, 1'b0);
    check("rehome", {homeCnt[3:0], holdCmd}, 4);
    homeDoneIn <= 1'b1;
    tick(1);
    homeDoneIn <= 1'b0;
    tick(4);
    check("homed complete", moveCompleteOut, 1);
  endtask : tHome
  task automatic tMoves;
    int pos[3] = '{1, 678, 1500};
    foreach (pos[i])
    begin
      plc.cmdStart(bcd(pos[i]), 1'b0, T);
      check("moves", goCnt, i + 1);
      check("target", targetPos, pos[i]);
      check("complete low", moveCompleteOut, 0);
      inPos();
      check("complete high", moveCompleteOut, 1);
    end
    plc.cmdStart(bcd(1501), 1'b0, T);
    check("too far", goCnt, 3);
    rdChk(positioner_pkg::ERRCODE_OFFS, 32'h000000A1, "range code");
    ahb(1'b1, positioner_pkg::CTRL_OFFS, 32'h00000002);
  endtask : tMoves
  task automatic tHold;
    plc.cmdStart(bcd(12), 1'b0, T);
    plc.setCtl(1'b1, 1'b0, 1'b0);
    check("held", {holdCmd, moveCompleteOut}, 2);
    plc.setCtl(1'b0, 1'b0, 1'b0);
    check("resumed", holdCmd, 0);
    plc.setCtl(1'b1, 1'b0, 1'b0);
    plc.setCtl(1'b1, 1'b1, 1'b0);
    check("cancel", {cancelCnt[3:0], holdCmd}, 32'h00000002);
    plc.setCtl(1'b0, 1'b0, 1'b0);
    check("no resume", moveCompleteOut, 0);
  endtask : tHold
  task automatic tInterp;
    ahb(1'b1, positioner_pkg::CTRL_OFFS, 32'h00000001);
    plc.cmdStart(bcd(3), 1'b1, T);
    check("interp", {interpCmd, targetPos}, 32'h00000803);
    inPos();
  endtask : tInterp
  task automatic tRestart;
    servoOnIn <= 1'b0;
    tick(3);
    check("servo off", moveCompleteOut, 0);
    plc.setCtl(1'b0, 1'b0, 1'b1);
    check("restart", restartCnt, 1);
    plc.setCtl(1'b0, 1'b0, 1'b0);
    servoOnIn <= 1'b1;
    plc.cmdStart(bcd(5), 1'b0, T);
    check("rehome needed", goCnt, 5);
    rdChk(positioner_pkg::ERRCODE_OFFS, 32'h00000C6F, "code again");
  endtask : tRestart
  initial
  begin
    {nrst, hwrite, htrans, haddr, hwdata, homeReversedIn} = '0;
    {coldErrIn, alarmIn, inPositionIn, homeDoneIn, sysBattLowIn, absBattLowIn} = '0;
    initDoneIn = 1'b1;
    servoOnIn = 1'b1;
    tick(5);
    nrst <= 1'b1;
    tick(2 * T);
    tReset();
    tNoHome();
    tHome();
    tMoves();
    tHold();
    tInterp();
    tRestart();
    tallyAndFinish();
  end
endmodule : tb_top
